// [verilog/smb_defines.vh]
// System control and mode status constants for the mode/bus config block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef SMB_DEFINES_VH
`define SMB_DEFINES_VH

// Register addresses (chosen, no offsets documented)
`define SMB_ADDR_W          4
`define SMB_ADDR_SYSCTL     4'h0
`define SMB_ADDR_MODESTAT   4'h2
`define SMB_ADDR_BUSCFG     4'h4

// System control field positions
`define SMB_BIT_EXT_EN      9
`define SMB_BIT_RAM_EN      8
`define SMB_BIT_XFER_MODE   1
`define SMB_BIT_RSV0        0

// Reset values
`define SMB_RST_RAM_EN      1'h1
`define SMB_RST_XFER_MODE   1'h1
`define SMB_RST_EXT_SINGLE  1'h0

// Mode pin encodings
`define SMB_MODE4           3'h4
`define SMB_MODE5           3'h5

// Mode status upper bits (fixed pattern 0101 0 then mode)
`define SMB_MSTAT_HI        5'h0A
`define SMB_MSTAT_LO        5'h0A

`endif

// [verilog/smb_mode_decode.v]
// Decodes unregistered mode pins into mode status code and extended flag.
// Assumes mode pins are already stable; the caller passes them in unregistered.
`timescale 1ns/1ps
`include "smb_defines.vh"
module smb_mode_decode
(
   input  wire [2:0] mode_pins_i,
   output reg  [2:0] mode_code_o,
   output reg        ext_mode_o,
   output reg        mode5_o
);
   always @*
   begin
      mode_code_o = 3'h0;
      ext_mode_o  = 1'b0;
      mode5_o     = 1'b0;
      case (mode_pins_i)
         `SMB_MODE4:
         begin
            mode_code_o = 3'h2;
            ext_mode_o  = 1'b1; // [R11]
         end
         `SMB_MODE5:
         begin
            mode_code_o = 3'h1;
            ext_mode_o  = 1'b1; // [R11]
            mode5_o     = 1'b1;
         end
         default:
         begin
            mode_code_o = 3'h0;
         end
      endcase
   end
endmodule // smb_mode_decode

// [verilog/smb_sysctl.v]
// System control low half, mode status and external bus pin assignment.
// Assumes synchronous inputs on clk_i; bus controller gives area widths.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "smb_defines.vh"

// Function
// R1: Bit 10 and bits 7..2 of system control always read zero.
// R2: Bit 0 of system control always reads one.
// R3: In extended mode the external bus enable stays one; writes ignored.
// R4: In single-chip mode external bus enable resets 0 and is writable.
// R5: External bus enable clear disables bus; set enables it.
// R6: Software clears external enable only with no external cycle active.
// R7: External cycle may overlap internal cycle per write buffer setting.
// R8: RAM enable resets to one; one enables on-chip RAM.
// R9: Software never clears RAM enable during on-chip RAM access.
// R10: Transfer mode bit resets one (short); zero selects full address.
// R11: Modes 4 and 5 are extended modes with external enable one.
// R12: Modes 4 and 5 use advanced 16-Mbyte addressing, ROM disabled.
// R13: Mode 4 resets to 16-bit bus; D,E,F address; H,I data.
// R14: Mode 4 with all areas 8-bit switches to 8-bit, port H data.
// R15: Mode 5 resets to 8-bit bus, port H data only.
// R16: Mode 5 with all areas 16-bit switches to 16-bit, H and I data.
// R17: Default port functions per pin group after reset in modes 4, 5.
// R18: Mode pins latched into mode status on read, released by reset.
// R19: Bus width tracks per-area width changes from the bus controller.
module smb_sysctl
(
   input  wire                   clk_i,
   input  wire                   rstn_i,
   input  wire                   ce_i,
   input  wire [`SMB_ADDR_W-1:0] addr_i,
   input  wire [15:0]            wdata_i,
   input  wire                   wr_i,
   input  wire                   rd_i,
   output reg  [15:0]            rdata_o,
   input  wire [2:0]             mode_pins_i,
   input  wire                   areas_all_8_i,
   input  wire                   areas_all_16_i,
   input  wire                   wbuf_en_i,
   output reg                    ext_bus_enable_o,
   output reg                    onchip_ram_enable_o,
   output reg                    xfer_ctrl_addr_mode_o,
   output reg                    rom_enable_o,
   output reg                    advanced_mode_o,
   output reg                    bus16_o,
   output reg                    port_i_data_o,
   output reg                    port_def_addr_o,
   output reg                    port_a_ctrl_o,
   output reg                    port_a_low_ctrl_o,
   output reg                    port_b_ctrl_o,
   output reg                    port_f_upper_pins_addr_o,
   output reg                    ext_overlap_o
);

   reg        ext_en_reg;
   reg        ext_en_next;
   reg        ram_en_reg;
   reg        xfer_mode_reg;
   reg        ext_mode_reg;
   reg        mode5_reg;
   reg        started_reg;
   reg  [2:0] mstat_reg;
   reg        mstat_held_reg;
   reg        bus16_reg;
   reg        bus16_next;
   reg [15:0] rdata_next;
   wire [2:0] mode_code;
   wire       ext_mode;
   wire       mode5;

   smb_mode_decode u_decode
   (
      .mode_pins_i (mode_pins_i),
      .mode_code_o (mode_code),
      .ext_mode_o  (ext_mode),
      .mode5_o     (mode5)
   );

   // Mode caught one cycle after reset release, not under reset
   always @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         started_reg  <= 1'b0;
         ext_mode_reg <= 1'b0;
         mode5_reg    <= 1'b0;
      end
      else if (ce_i && !started_reg)
      begin
         started_reg  <= 1'b1;
         ext_mode_reg <= ext_mode;             // [R11]
         mode5_reg    <= mode5;
      end
   end

   always @*
   begin
      ext_en_next = ext_en_reg;
      if (!started_reg)
         ext_en_next = ext_mode;                // [R4] [R11]
      else if (ext_mode_reg)
         ext_en_next = 1'b1;                    // [R3]
      else if (wr_i && addr_i == `SMB_ADDR_SYSCTL)
         ext_en_next = wdata_i[`SMB_BIT_EXT_EN]; // [R4] [R5]
   end

   // Width follows bus controller; reset value set by mode
   always @*
   begin
      bus16_next = bus16_reg;
      if (!started_reg)
         bus16_next = ~mode5;                   // [R13] [R15]
      else if (!mode5_reg && areas_all_8_i)
         bus16_next = 1'b0;                     // [R14] [R19]
      else if (mode5_reg && areas_all_16_i)
         bus16_next = 1'b1;                     // [R16] [R19]
      else if (!mode5_reg && areas_all_16_i)
         bus16_next = 1'b1;                     // [R19]
      else if (mode5_reg && areas_all_8_i)
         bus16_next = 1'b0;                     // [R19]
   end

   always @*
   begin
      rdata_next = 16'h0000;                    // [R1]
      case (addr_i)
         `SMB_ADDR_SYSCTL:
         begin
            rdata_next[`SMB_BIT_EXT_EN]    = ext_en_reg;
            rdata_next[`SMB_BIT_RAM_EN]    = ram_en_reg;
            rdata_next[`SMB_BIT_XFER_MODE] = xfer_mode_reg;
            rdata_next[`SMB_BIT_RSV0]      = 1'b1; // [R2]
         end
         `SMB_ADDR_MODESTAT:
         begin
            // Latch shows live pins on first read after reset [R18]
            rdata_next[15:8] = {`SMB_MSTAT_HI,
                                mstat_held_reg ? mstat_reg : mode_code};
            rdata_next[7:0]  = {`SMB_MSTAT_LO,
                                mstat_held_reg ? mstat_reg : mode_code};
         end
         `SMB_ADDR_BUSCFG:
         begin
            rdata_next[0] = bus16_reg;
            rdata_next[1] = ext_mode_reg;
            rdata_next[2] = mode5_reg;
         end
         default:
         begin
            rdata_next = 16'h0000;
         end
      endcase
   end

   always @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         ext_en_reg     <= `SMB_RST_EXT_SINGLE;
         ram_en_reg     <= `SMB_RST_RAM_EN;     // [R8]
         xfer_mode_reg  <= `SMB_RST_XFER_MODE;  // [R10]
         mstat_reg      <= 3'h0;
         mstat_held_reg <= 1'b0;
         bus16_reg      <= 1'b0;
         rdata_o        <= 16'h0000;
      end
      else if (ce_i)
      begin
         ext_en_reg <= ext_en_next;
         bus16_reg  <= bus16_next;
         if (wr_i && addr_i == `SMB_ADDR_SYSCTL)
         begin
            ram_en_reg    <= wdata_i[`SMB_BIT_RAM_EN];    // [R8]
            xfer_mode_reg <= wdata_i[`SMB_BIT_XFER_MODE]; // [R10]
         end
         if (rd_i && addr_i == `SMB_ADDR_MODESTAT && !mstat_held_reg)
         begin
            mstat_reg      <= mode_code;         // [R18]
            mstat_held_reg <= 1'b1;
         end
         rdata_o <= rd_i ? rdata_next : 16'h0000;
      end
   end

   // Pin functions registered so all outputs come from flops
   always @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         ext_bus_enable_o         <= 1'b0;
         onchip_ram_enable_o      <= 1'b1;
         xfer_ctrl_addr_mode_o    <= 1'b1;
         rom_enable_o             <= 1'b1;
         advanced_mode_o          <= 1'b0;
         bus16_o                  <= 1'b0;
         port_i_data_o            <= 1'b0;
         port_def_addr_o          <= 1'b0;
         port_a_ctrl_o            <= 1'b0;
         port_a_low_ctrl_o        <= 1'b0;
         port_b_ctrl_o            <= 1'b0;
         port_f_upper_pins_addr_o <= 1'b0;
         ext_overlap_o            <= 1'b0;
      end
      else if (ce_i)
      begin
         ext_bus_enable_o      <= ext_en_reg;             // [R5]
         onchip_ram_enable_o   <= ram_en_reg;             // [R8]
         xfer_ctrl_addr_mode_o <= xfer_mode_reg;          // [R10]
         rom_enable_o          <= ~ext_mode_reg;          // [R12]
         advanced_mode_o       <= ext_mode_reg;           // [R12]
         bus16_o               <= ext_mode_reg & bus16_reg;
         // Port I carries data only on a 16-bit bus
         port_i_data_o   <= ext_mode_reg & ext_en_reg & bus16_reg; // [R13]
         port_def_addr_o <= ext_mode_reg & ext_en_reg;   // [R13]
         port_a_ctrl_o   <= ext_mode_reg & ext_en_reg;   // [R17]
         port_b_ctrl_o   <= ext_mode_reg & ext_en_reg;   // [R17]
         // Low A pins and upper F pins stay I/O after reset
         port_a_low_ctrl_o        <= 1'b0;               // [R17]
         port_f_upper_pins_addr_o <= 1'b0;               // [R17]
         // Overlap only when write buffer lets bus run alone
         ext_overlap_o <= ext_en_reg & wbuf_en_i;        // [R7]
      end
   end

endmodule // smb_sysctl

// [verif/smb_busctl_model.sv]
// Bus controller stand-in giving the per-area width summary.
// Assumes sel_i from the bench: 1 all 8-bit, 2 all 16-bit, else mixed.
`timescale 1ns/1ps
module smb_busctl_model
(
   input  wire       clk_i,
   input  wire [1:0] sel_i,
   output reg        all8_o  = 1'b0,
   output reg        all16_o = 1'b0,
   output reg        wbuf_o  = 1'b0
);
   // Registered so both summaries never glitch high together
   always @(posedge clk_i)
   begin
      all8_o  <= (sel_i == 2'h1);
      all16_o <= (sel_i == 2'h2);
      wbuf_o  <= sel_i[1];
   end
endmodule // smb_busctl_model

// [verif/smb_sysctl_props.sv]
// Checker for the system control and mode configuration block.
// Assumes mode pins only change while reset is held.
`timescale 1ns/1ps
`include "smb_defines.vh"
module smb_sysctl_props
(
   input wire                   clk_i,
   input wire                   rstn_i,
   input wire [`SMB_ADDR_W-1:0] addr_i,
   input wire [15:0]            wdata_i,
   input wire                   wr_i,
   input wire                   rd_i,
   input wire [15:0]            rdata_o,
   input wire [2:0]             mode_pins_i,
   input wire                   areas_all_8_i,
   input wire                   areas_all_16_i,
   input wire                   ext_bus_enable_o,
   input wire                   onchip_ram_enable_o,
   input wire                   xfer_ctrl_addr_mode_o,
   input wire                   rom_enable_o,
   input wire                   advanced_mode_o,
   input wire                   bus16_o,
   input wire                   port_i_data_o,
   input wire                   port_def_addr_o,
   input wire                   port_a_ctrl_o,
   input wire                   port_a_low_ctrl_o,
   input wire                   port_b_ctrl_o,
   input wire                   port_f_upper_pins_addr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Outputs settle two edges after release; wait three
   reg  [1:0] cnt_reg = 2'h0;
   wire [1:0] cnt_next = (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
   always @(posedge clk_i)
      cnt_reg <= rstn_i ? cnt_next : 2'h0;
   wire m4  = cnt_reg == 2'h3 && mode_pins_i == `SMB_MODE4;
   wire m5  = cnt_reg == 2'h3 && mode_pins_i == `SMB_MODE5;
   wire sgl = cnt_reg == 2'h3 && !(m4 || m5);
   wire rd0 = rd_i && addr_i == `SMB_ADDR_SYSCTL;
   wire wr0 = wr_i && addr_i == `SMB_ADDR_SYSCTL;
   property p_rsv; $past(rd0) |-> rdata_o[10] == 1'b0 && rdata_o[7:2] == 6'h00;
   endproperty
   property p_one; $past(rd0) |-> rdata_o[0] == 1'b1; endproperty
   property p_ext; m4 || m5 |-> ext_bus_enable_o; endproperty
   property p_extw; sgl && wr0 |-> ##2 ext_bus_enable_o == $past(wdata_i[9], 2);
   endproperty
   property p_rst; $rose(rstn_i) |-> onchip_ram_enable_o && xfer_ctrl_addr_mode_o;
   endproperty
   property p_wr; cnt_reg == 2'h3 && wr0 |-> ##2
      onchip_ram_enable_o == $past(wdata_i[8], 2) &&
      xfer_ctrl_addr_mode_o == $past(wdata_i[1], 2);
   endproperty
   property p_adv; m4 || m5 |-> !rom_enable_o && advanced_mode_o; endproperty
   property p_w4; (m4 && !areas_all_8_i)[*3] |-> bus16_o && port_i_data_o;
   endproperty
   property p_w4n; (m4 && areas_all_8_i)[*3] |-> !bus16_o && !port_i_data_o;
   endproperty
   property p_w5; (m5 && !areas_all_16_i)[*3] |-> !bus16_o && !port_i_data_o;
   endproperty
   property p_w5w; (m5 && areas_all_16_i)[*3] |-> bus16_o && port_i_data_o;
   endproperty
   property p_pins; m4 || m5 |-> port_a_ctrl_o && port_b_ctrl_o && port_def_addr_o
      && !port_a_low_ctrl_o && !port_f_upper_pins_addr_o;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   a_one: assert property (p_one) else $error("bit0 clear");
   a_ext: assert property (p_ext) else $error("ext enable low");
   a_extw: assert property (p_extw) else $error("ext write lost");
   a_rst: assert property (p_rst) else $error("reset values");
   a_wr: assert property (p_wr) else $error("ram/xfer write");
   a_adv: assert property (p_adv) else $error("rom or addressing");
   a_w4: assert property (p_w4) else $error("mode4 width");
   a_w4n: assert property (p_w4n) else $error("mode4 8bit");
   a_w5: assert property (p_w5) else $error("mode5 width");
   a_w5w: assert property (p_w5w) else $error("mode5 16bit");
   a_pins: assert property (p_pins) else $error("port defaults");
   c_w4n: cover property (m4 && areas_all_8_i);
   c_w5w: cover property (m5 && areas_all_16_i);
   c_wr: cover property (sgl && wr0);
endmodule // smb_sysctl_props
bind smb_sysctl smb_sysctl_props u_props (.clk_i(clk_i), .rstn_i(rstn_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .mode_pins_i(mode_pins_i),
   .areas_all_8_i(areas_all_8_i), .areas_all_16_i(areas_all_16_i),
   .ext_bus_enable_o(ext_bus_enable_o),
   .onchip_ram_enable_o(onchip_ram_enable_o),
   .xfer_ctrl_addr_mode_o(xfer_ctrl_addr_mode_o),
   .rom_enable_o(rom_enable_o), .advanced_mode_o(advanced_mode_o),
   .bus16_o(bus16_o), .port_i_data_o(port_i_data_o),
   .port_def_addr_o(port_def_addr_o), .port_a_ctrl_o(port_a_ctrl_o),
   .port_a_low_ctrl_o(port_a_low_ctrl_o), .port_b_ctrl_o(port_b_ctrl_o),
   .port_f_upper_pins_addr_o(port_f_upper_pins_addr_o));

// [verif/system_mode_bus_config_tb.sv]
// Testbench for the system control and mode configuration block.
// Assumes the checker is bound in and the bus controller model beside.
`timescale 1ns/1ps
`include "smb_defines.vh"
module system_mode_bus_config_tb;
   reg         clk_i = 1'b0;
   reg         rstn_i = 1'b0;
   reg  [3:0]  addr_i = 4'h0;
   reg  [15:0] wdata_i = 16'h0000;
   reg         wr_i = 1'b0;
   reg         rd_i = 1'b0;
   reg  [2:0]  mode_pins_i = 3'h0;
   reg  [1:0]  sel = 2'h0;
   wire [15:0] rdata_o;
   wire        a8, a16, wb, ext, ram, bus16, pid;
   integer     err_count = 0;
   integer     n_compared = 0;
   initial
      forever #12.5 clk_i = ~clk_i;
   smb_busctl_model u_bc (.clk_i(clk_i), .sel_i(sel), .all8_o(a8),
      .all16_o(a16), .wbuf_o(wb));
   smb_sysctl dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .mode_pins_i(mode_pins_i), .areas_all_8_i(a8),
      .areas_all_16_i(a16), .wbuf_en_i(wb), .ext_bus_enable_o(ext),
      .onchip_ram_enable_o(ram), .xfer_ctrl_addr_mode_o(),
      .rom_enable_o(), .advanced_mode_o(), .bus16_o(bus16),
      .port_i_data_o(pid), .port_def_addr_o(), .port_a_ctrl_o(),
      .port_a_low_ctrl_o(), .port_b_ctrl_o(),
      .port_f_upper_pins_addr_o(), .ext_overlap_o());
   task cmp16(input [15:0] got, input [15:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR %0t read %h want %h", $time, got, exp);
      end
   end
   endtask
   task cmp1(input got, input exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR %0t flag %b want %b", $time, got, exp);
      end
   end
   endtask
   task close_out;
   begin
      if (err_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   task rst(input [2:0] m);
   begin
      @(posedge clk_i);
      rstn_i <= 1'b0;
      mode_pins_i <= m;
      sel <= 2'h0;
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   end
   endtask
   task wr(input [3:0] a, input [15:0] d);
   begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   end
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input [3:0] a, input [15:0] e);
   begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 cmp16(rdata_o, e);
   end
   endtask
   task wbus(input e);
      integer i;
   begin
      for (i = 0; i < 8 && bus16 !== e; i = i + 1)
         @(posedge clk_i);
      #1 cmp1(bus16, e);
      cmp1(pid, e);
   end
   endtask
   initial
   begin
      rst(3'h0);
      rd(`SMB_ADDR_SYSCTL, 16'h0103);
      wr(`SMB_ADDR_SYSCTL, 16'hFFFF);
      rd(`SMB_ADDR_SYSCTL, 16'h0303);
      cmp1(ext, 1'b1);
      wr(`SMB_ADDR_SYSCTL, 16'h0000);
      rd(`SMB_ADDR_SYSCTL, 16'h0001);
      cmp1(ram, 1'b0);
      rd(4'h6, 16'h0000);
      rd(`SMB_ADDR_MODESTAT, 16'h5050);
      rst(`SMB_MODE4);
      rd(`SMB_ADDR_SYSCTL, 16'h0303);
      wr(`SMB_ADDR_SYSCTL, 16'h0000);
      rd(`SMB_ADDR_SYSCTL, 16'h0201);
      wbus(1'b1);
      sel <= 2'h1;
      wbus(1'b0);
      rd(`SMB_ADDR_MODESTAT, 16'h5252);
      mode_pins_i <= 3'h0;
      rd(`SMB_ADDR_MODESTAT, 16'h5252);
      rst(`SMB_MODE5);
      wbus(1'b0);
      sel <= 2'h2;
      wbus(1'b1);
      rd(`SMB_ADDR_MODESTAT, 16'h5151);
      close_out;
   end
   initial
   begin
      repeat (2000) @(posedge clk_i);
      err_count = err_count + 1;
      close_out;
   end
endmodule // system_mode_bus_config_tb
